//--- logic/ict_core.sv
// instruction timing and flag unit with a wishbone register port
`timescale 1ns/1ps

module ict_core (
	input wire logic clock, // block clock, 50 MHz
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic busy_o // timed execution running
);
	logic rst_meta_q, rst_sync_n;
	logic bus8_q;
	logic [31:0] instr_q, opnd_q, stack_q;
	logic [15:0] result_q, flags_q, clocks_q, count_q;
	logic [3:0] xfers_q, len_q;
	logic illegal_q, done_q;
	ict_pkg::ict_state_e state_q;
	ict_ea_if ea ();

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// bus decode; one wait state, so ack is a single-cycle pulse
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i;
	wire [5:0] widx = wb_adr_i[7:2];
	wire hit_ctrl = widx == ict_pkg::OFF_CTRL[7:2];
	wire hit_instr = widx == ict_pkg::OFF_INSTR[7:2];
	wire hit_opnd = widx == ict_pkg::OFF_OPND[7:2];
	wire hit_stack = widx == ict_pkg::OFF_STACK[7:2];
	wire hit_result = widx == ict_pkg::OFF_RESULT[7:2];
	wire hit_timing = widx == ict_pkg::OFF_TIMING[7:2];
	wire hit_tab = widx == ict_pkg::OFF_EA_TAB[7:2];
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire start_hit = wr & hit_ctrl & wb_sel_i[0]
		& wb_dat_i[ict_pkg::START_BIT];
	// a start while running is dropped, the first one keeps its timing
	wire go = start_hit & (state_q == ict_pkg::ST_IDLE);
	// the start write also carries the bus width; its timing must use it
	wire bus8_now = (wr & hit_ctrl & wb_sel_i[0])
		? wb_dat_i[ict_pkg::BUS8_BIT] : bus8_q;

	// instruction fields
	wire [3:0] op_raw = instr_q[ict_pkg::OP_LSB +: 4];
	wire [3:0] form = instr_q[ict_pkg::FORM_LSB +: 4];
	wire word = instr_q[ict_pkg::WORD_BIT];
	wire odd = instr_q[ict_pkg::ODD_BIT];
	wire [1:0] seg = instr_q[ict_pkg::SEG_LSB +: 2];
	wire [7:0] cnt = instr_q[ict_pkg::CNT_LSB +: 8];
	wire [15:0] dst = opnd_q[15:0];
	wire [15:0] src = opnd_q[31:16];
	wire [15:0] fl_in = stack_q[15:0];
	wire [15:0] stk = stack_q[31:16];
	assign ea.mode = instr_q[ict_pkg::MODE_LSB +: 3];
	assign ea.wr = wr & hit_tab;
	assign ea.wdata = wb_dat_i;
	assign ea.wmask = wmask;

	// inclusive or and its flags, byte forms look at the low byte only
	wire [15:0] or_res = word ? (dst | src) : {8'h00, dst[7:0] | src[7:0]};
	wire or_s = word ? or_res[15] : or_res[7];
	wire or_z = word ? (or_res == 16'h0000) : (or_res[7:0] == 8'h00);
	wire or_p = ~^or_res[7:0];
	wire [15:0] or_keep = fl_in & ~(16'h0001 << ict_pkg::F_O)
		& ~(16'h0001 << ict_pkg::F_C) & ~(16'h0001 << ict_pkg::F_S)
		& ~(16'h0001 << ict_pkg::F_Z) & ~(16'h0001 << ict_pkg::F_P)
		& ~(16'h0001 << ict_pkg::F_A);
	wire [15:0] or_flags = or_keep | (16'(or_s) << ict_pkg::F_S)
		| (16'(or_z) << ict_pkg::F_Z) | (16'(or_p) << ict_pkg::F_P);

	// rotate through carry, n already reduced modulo the ring length
	function automatic logic [16:0] rot_carry(input logic [15:0] v,
		input logic cin, input logic wd, input logic left,
		input logic [4:0] n);
		logic [15:0] r;
		logic c, nc;
		r = v;
		c = cin;
		nc = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			if (5'(i) < n)
			begin
				if (left)
				begin
					nc = wd ? r[15] : r[7];
					r = wd ? {r[14:0], c} : {8'h00, r[6:0], c};
				end
				else
				begin
					nc = r[0];
					r = wd ? {c, r[15:1]} : {8'h00, c, r[7:1]};
				end
				c = nc;
			end
		end
		return {c, r};
	endfunction

	// ring is 17 bits for words and 9 for bytes; timing uses the raw count
	wire by_one = (form == 4'h0) | (form == 4'h2);
	wire [7:0] rcnt = by_one ? 8'h01 : cnt;
	wire [7:0] rmod = word ? (rcnt % 8'd17) : (rcnt % 8'd9);
	wire left = (op_raw == 4'(ict_pkg::OP_ROT_LEFT));
	wire [16:0] rot = rot_carry(dst, fl_in[ict_pkg::F_C], word, left,
		rmod[4:0]);
	wire rot_msb = word ? rot[15] : rot[7];
	wire rot_msb1 = word ? rot[14] : rot[6];
	wire rot_o = left ? (rot_msb ^ rot[16]) : (rot_msb ^ rot_msb1);
	wire [15:0] rot_flags = (rcnt == 8'h00) ? fl_in
		: ((fl_in & ~(16'h0001 << ict_pkg::F_O)
		& ~(16'h0001 << ict_pkg::F_C))
		| (16'(rot_o) << ict_pkg::F_O)
		| (16'(rot[16]) << ict_pkg::F_C));

	// per-class cost table: base clocks, transfers, length, result, flags
	logic [15:0] base, res, flg;
	logic [3:0] xfers, len;
	logic ea_used, per_bit, illegal, wide;
	always_comb
	begin
		base = 16'h0000;
		xfers = 4'h0;
		len = 4'h1;
		ea_used = 1'b0;
		per_bit = 1'b0;
		illegal = 1'b0;
		wide = word;
		res = dst;
		flg = fl_in;
		case (op_raw)
			4'(ict_pkg::OP_OR):
			begin
				res = or_res;
				flg = or_flags;
				len = 4'h2;
				case (form)
					4'h0: base = ict_pkg::CLK_OR_RR;
					4'h1:
					begin
						base = ict_pkg::CLK_OR_RM;
						xfers = 4'h1;
						ea_used = 1'b1;
					end
					4'h2:
					begin
						base = ict_pkg::CLK_OR_MR;
						xfers = 4'h2;
						ea_used = 1'b1;
					end
					4'h3: base = ict_pkg::CLK_OR_AI;
					4'h4:
					begin
						base = ict_pkg::CLK_OR_AI;
						len = 4'h3;
					end
					4'h5:
					begin
						base = ict_pkg::CLK_OR_MI;
						xfers = 4'h2;
						ea_used = 1'b1;
						len = 4'h3;
					end
					default: illegal = 1'b1;
				endcase
			end
			4'(ict_pkg::OP_OUT):
			begin
				xfers = 4'h1;
				case (form)
					4'h0:
					begin
						base = ict_pkg::CLK_OUT_IMM;
						len = 4'h2;
					end
					4'h1: base = ict_pkg::CLK_OUT_PTR;
					default: illegal = 1'b1;
				endcase
			end
			4'(ict_pkg::OP_POP):
			begin
				wide = 1'b1;
				res = stk;
				xfers = 4'h1;
				base = ict_pkg::CLK_POP_REG;
				case (form)
					4'h0: ;
					4'h1: illegal = (seg == ict_pkg::SEG_CODE);
					4'h2:
					begin
						base = ict_pkg::CLK_POP_MEM;
						xfers = 4'h2;
						ea_used = 1'b1;
						len = 4'h2;
					end
					default: illegal = 1'b1;
				endcase
			end
			4'(ict_pkg::OP_FLAG_RESTORE):
			begin
				wide = 1'b1;
				base = ict_pkg::CLK_RESTORE;
				xfers = 4'h1;
				flg = (stk & ict_pkg::FLAG_MASK)
					| (fl_in & ~ict_pkg::FLAG_MASK);
			end
			4'(ict_pkg::OP_PUSH):
			begin
				wide = 1'b1;
				xfers = 4'h1;
				case (form)
					4'h0: base = ict_pkg::CLK_PUSH_REG;
					4'h1: base = ict_pkg::CLK_PUSH_SEG;
					4'h2:
					begin
						base = ict_pkg::CLK_PUSH_MEM;
						xfers = 4'h2;
						ea_used = 1'b1;
						len = 4'h2;
					end
					default: illegal = 1'b1;
				endcase
			end
			4'(ict_pkg::OP_FLAG_SAVE):
			begin
				wide = 1'b1;
				base = ict_pkg::CLK_SAVE;
				xfers = 4'h1;
				res = fl_in;
			end
			4'(ict_pkg::OP_ROT_LEFT), 4'(ict_pkg::OP_ROT_RIGHT):
			begin
				res = rot[15:0];
				flg = rot_flags;
				len = 4'h2;
				case (form)
					4'h0: base = ict_pkg::CLK_ROT_ONE;
					4'h1:
					begin
						base = ict_pkg::CLK_ROT_CNT;
						per_bit = 1'b1;
					end
					4'h2:
					begin
						base = ict_pkg::CLK_ROT_MEM1;
						xfers = 4'h2;
						ea_used = 1'b1;
					end
					4'h3:
					begin
						base = ict_pkg::CLK_ROT_MEMC;
						xfers = 4'h2;
						ea_used = 1'b1;
						per_bit = 1'b1;
					end
					default: illegal = 1'b1;
				endcase
			end
			default: illegal = 1'b1;
		endcase
	end

	// total clocks: base, address cost, per-bit term, word penalty
	wire [15:0] ea_add = ea_used ? 16'(ea.cost) : 16'h0000;
	wire [15:0] bit_add = per_bit ? 16'(cnt) * ict_pkg::CLK_PER_BIT
		: 16'h0000;
	wire word_hit = wide & (bus8_now | odd);
	wire [15:0] pen = word_hit ? 16'(xfers) * ict_pkg::CLK_WORD_PEN
		: 16'h0000;
	wire [15:0] total = base + ea_add + bit_add + pen;

	// software registers; bus8 steers the penalty above
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			bus8_q <= ict_pkg::REG_RST[0];
			instr_q <= ict_pkg::REG_RST;
			opnd_q <= ict_pkg::REG_RST;
			stack_q <= ict_pkg::REG_RST;
		end
		else
		begin
			if (wr & hit_ctrl & wb_sel_i[0])
				bus8_q <= wb_dat_i[ict_pkg::BUS8_BIT];
			if (wr & hit_instr)
				instr_q <= (instr_q & ~wmask) | (wb_dat_i & wmask);
			if (wr & hit_opnd)
				opnd_q <= (opnd_q & ~wmask) | (wb_dat_i & wmask);
			if (wr & hit_stack)
				stack_q <= (stack_q & ~wmask) | (wb_dat_i & wmask);
		end
	end

	// read mux; unmapped words read as zero and are still acknowledged
	wire [31:0] timing_word = {5'h00, done_q, busy_o, illegal_q, len_q,
		xfers_q, clocks_q};
	wire [31:0] rd_word = hit_ctrl ? {30'h0, bus8_q, 1'b0}
		: hit_instr ? instr_q : hit_opnd ? opnd_q : hit_stack ? stack_q
		: hit_result ? {flags_q, result_q} : hit_timing ? timing_word
		: hit_tab ? ea.table_q : 32'h00000000;

	// bus answer registers
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= rd_word;
		end
	end

	// sequencer: latches the outcome at start, then stays busy for the
	// computed clock count; illegal forms finish at once and keep results
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_q <= ict_pkg::ST_IDLE;
			busy_o <= 1'b0;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			count_q <= 16'h0000;
			clocks_q <= 16'h0000;
			xfers_q <= 4'h0;
			len_q <= 4'h0;
			result_q <= 16'h0000;
			flags_q <= 16'h0000;
		end
		else
		begin
			case (state_q)
				ict_pkg::ST_IDLE:
				begin
					if (go)
					begin
						illegal_q <= illegal;
						clocks_q <= total;
						xfers_q <= xfers;
						len_q <= len;
						done_q <= illegal;
						if (!illegal)
						begin
							result_q <= res;
							flags_q <= flg;
							count_q <= total;
							busy_o <= 1'b1;
							state_q <= ict_pkg::ST_RUN;
						end
					end
				end
				ict_pkg::ST_RUN:
				begin
					count_q <= count_q - 16'h0001;
					if (count_q == 16'h0001)
					begin
						busy_o <= 1'b0;
						done_q <= 1'b1;
						state_q <= ict_pkg::ST_IDLE;
					end
				end
				default: state_q <= ict_pkg::ST_IDLE;
			endcase
		end
	end

	ict_ea_table u_ea (
		.clock(clock),
		.rst_n(rst_sync_n),
		.ea(ea)
	);

	// checks on the latched outcome of each accepted start
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_sync_n);

	wire is_op_or = op_raw == 4'(ict_pkg::OP_OR);
	wire is_rot = left | (op_raw == 4'(ict_pkg::OP_ROT_RIGHT));

	a_odd_word_pen: assert property (go && !bus8_now && wide && odd
		|=> clocks_q == $past(base) + $past(ea_add) + $past(bit_add)
		+ 16'($past(xfers)) * 16'h0004)
		else $error("odd word penalty wrong");
	a_narrow_pen: assert property (go && bus8_now && wide
		|=> clocks_q == $past(base) + $past(ea_add) + $past(bit_add)
		+ 16'($past(xfers)) * 16'h0004)
		else $error("narrow bus penalty wrong");
	a_or_flags: assert property (go && is_op_or && !illegal
		|=> !flags_q[ict_pkg::F_O] && !flags_q[ict_pkg::F_C]
		&& flags_q[10:8] == $past(fl_in[10:8]))
		else $error("or flags wrong");
	a_or_reg_clocks: assert property (go && is_op_or && form == 4'h0
		|=> clocks_q == 16'h0003 ##1 busy_o [*2] ##1 !busy_o && done_q)
		else $error("or register timing wrong");
	a_out_ptr: assert property (go && op_raw == 4'h1 && form == 4'h1
		|=> xfers_q == 4'h1 && len_q == 4'h1
		&& clocks_q == 16'h0008 + $past(pen))
		else $error("port write timing wrong");
	a_pop_code_seg: assert property (go && op_raw == 4'h2
		&& form == 4'h1 && seg == 2'h1
		|=> illegal_q && done_q && !busy_o)
		else $error("code segment load not refused");
	a_restore_load: assert property (go && op_raw == 4'h3
		|=> flags_q == (($past(stk) & 16'h0FD5)
		| ($past(fl_in) & 16'hF02A)) && clocks_q == 16'h0008 + $past(pen))
		else $error("flag restore wrong");
	a_push_reg: assert property (go && op_raw == 4'h4 && form == 4'h0
		|=> clocks_q == 16'h000B + $past(pen) && xfers_q == 4'h1)
		else $error("stack store timing wrong");
	a_save_flags: assert property (go && op_raw == 4'h5
		|=> result_q == $past(fl_in) && flags_q == $past(fl_in)
		&& clocks_q == 16'h000A + $past(pen))
		else $error("flag save wrong");
	a_rot_only_oc: assert property (go && is_rot && !illegal
		|=> ((flags_q ^ $past(fl_in)) & 16'hF7FE) == 16'h0000)
		else $error("rotate touched other flags");
	a_rot_mem_cnt: assert property (go && is_rot && form == 4'h3
		|=> clocks_q == 16'h0014 + 16'($past(ea.cost))
		+ 16'($past(cnt)) * 16'h0004 + $past(pen))
		else $error("rotate memory count timing wrong");
	a_ea_cost_add: assert property (go && ea_used && !illegal
		|=> clocks_q == $past(base) + 16'($past(ea.cost))
		+ $past(bit_add) + $past(pen))
		else $error("address cost not added");
	a_busy_ends: assert property (busy_o && count_q == 16'h0001
		|=> !busy_o && done_q)
		else $error("busy did not end on count");
endmodule

//--- common/ict_pkg.sv
// package: register map, field layout and clock figures of the timing unit
package ict_pkg;
	// register byte offsets on the wishbone port
	localparam logic [7:0] OFF_CTRL = 8'h00, OFF_INSTR = 8'h04,
		OFF_OPND = 8'h08, OFF_STACK = 8'h0C, OFF_RESULT = 8'h10,
		OFF_TIMING = 8'h14, OFF_EA_TAB = 8'h18;
	// control register fields
	localparam int START_BIT = 0, BUS8_BIT = 1;
	// instruction register fields
	localparam int OP_LSB = 0, FORM_LSB = 4, WORD_BIT = 8, ODD_BIT = 9,
		MODE_LSB = 10, SEG_LSB = 14, CNT_LSB = 16;
	// timing register fields
	localparam int CLK_LSB = 0, XFER_LSB = 16, LEN_LSB = 20,
		ILL_BIT = 24, BUSY_BIT = 25, DONE_BIT = 26;
	// flags word bit positions
	localparam int F_C = 0, F_P = 2, F_A = 4, F_Z = 6, F_S = 7, F_T = 8,
		F_I = 9, F_D = 10, F_O = 11;
	localparam logic [15:0] FLAG_MASK = 16'h0FD5;
	localparam logic [1:0] SEG_CODE = 2'h1;
	// reset values
	localparam logic [31:0] REG_RST = 32'h00000000;
	localparam logic [31:0] EA_TAB_RST = 32'h00000000;
	// clock figures per operand form
	localparam logic [15:0] CLK_OR_RR = 16'h0003, CLK_OR_RM = 16'h0009,
		CLK_OR_MR = 16'h0010, CLK_OR_AI = 16'h0004, CLK_OR_MI = 16'h0011;
	localparam logic [15:0] CLK_OUT_IMM = 16'h000A, CLK_OUT_PTR = 16'h0008;
	localparam logic [15:0] CLK_POP_REG = 16'h0008, CLK_POP_MEM = 16'h0011;
	localparam logic [15:0] CLK_RESTORE = 16'h0008, CLK_SAVE = 16'h000A;
	localparam logic [15:0] CLK_PUSH_REG = 16'h000B,
		CLK_PUSH_SEG = 16'h000A, CLK_PUSH_MEM = 16'h0010;
	localparam logic [15:0] CLK_ROT_ONE = 16'h0002, CLK_ROT_CNT = 16'h0008,
		CLK_ROT_MEM1 = 16'h000F, CLK_ROT_MEMC = 16'h0014;
	localparam logic [15:0] CLK_PER_BIT = 16'h0004, CLK_WORD_PEN = 16'h0004;
	// instruction classes
	typedef enum logic [3:0] {
		OP_OR, OP_OUT, OP_POP, OP_FLAG_RESTORE, OP_PUSH, OP_FLAG_SAVE,
		OP_ROT_LEFT, OP_ROT_RIGHT
	} ict_op_e;
	// execution sequencer
	typedef enum logic {ST_IDLE, ST_RUN} ict_state_e;
endpackage

//--- common/ict_ea_if.sv
// interface: address cost table write port and lookup
`timescale 1ns/1ps
interface ict_ea_if;
	logic [2:0] mode;
	logic [3:0] cost;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] wmask;
	logic [31:0] table_q;
	modport core (output mode, wr, wdata, wmask, input cost, table_q);
	modport tab (input mode, wr, wdata, wmask, output cost, table_q);
endinterface

//--- logic/ict_ea_table.sv
// address calculation cost table, one nibble per addressing mode
`timescale 1ns/1ps
module ict_ea_table (
	input wire logic clock, // block clock
	input wire logic rst_n, // synchronised reset, active low
	ict_ea_if.tab ea // table write and lookup
);
	logic [3:0] entry_q [8];
	genvar g;

	// each entry takes its own nibble of the table word, byte lanes honoured
	generate
		for (g = 0; g < 8; g++)
		begin : g_entry
			wire [3:0] m = ea.wmask[4*g +: 4];
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
					entry_q[g] <= ict_pkg::EA_TAB_RST[4*g +: 4];
				else if (ea.wr)
					entry_q[g] <= (entry_q[g] & ~m) | (ea.wdata[4*g +: 4] & m);
			end
			assign ea.table_q[4*g +: 4] = entry_q[g];
		end
	endgenerate

	// lookup by addressing mode of the current instruction
	assign ea.cost = entry_q[ea.mode];
endmodule

//--- tb/ict_bus_model.sv
// wishbone master model standing in for the system side of the unit
`timescale 1ns/1ps
module ict_bus_model (
	input wire logic clock, // block clock
	output logic cyc, // bus cycle
	output logic stb, // strobe
	output logic we, // write enable
	output logic [7:0] adr, // byte address
	output logic [3:0] sel, // byte lanes
	output logic [31:0] dat, // write data
	input wire logic ack // acknowledge from the unit
);
	// idle bus at time zero
	initial
	begin
		{cyc, stb, we, adr, sel} = 15'h0000;
		dat = 32'h00000000;
	end
	// one classic cycle held until ack is seen; a dead slave is left to
	// the bench watchdog
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
		@(posedge clock);
		while (ack !== 1'b1)
			@(posedge clock);
		{cyc, stb, we} <= 3'b000;
		dat <= ~d; // released data must not keep its last value
		@(posedge clock);
	endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the instruction timing unit
`timescale 1ns/1ps
module tb_top;
	logic clock, rst_n, cyc, stb, we, ack, busy;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dwr, drd, opnd, stk, ea, ins, last_r, last_m, t;
	logic [63:0] er;
	logic [31:0] exp_q[$], msk_q[$];
	int bexp_q[$];
	int failures, n_compared, bcnt, n;
	int nf[8] = '{6, 2, 3, 1, 3, 1, 4, 4};

	// 50 MHz clock
	initial clock = 1'b0;
	always #10 clock = ~clock;

	ict_core ict_core_inst (
		.clock(clock),
		.rst_n(rst_n),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(dwr),
		.wb_dat_o(drd),
		.wb_ack_o(ack),
		.busy_o(busy)
	);
	ict_bus_model ict_bus_model_inst (
		.clock(clock),
		.cyc(cyc),
		.stb(stb),
		.we(we),
		.adr(adr),
		.sel(sel),
		.dat(dwr),
		.ack(ack)
	);

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ict_bus_model_inst.xfer(1'b1, a, 4'hF, d);
	endtask
	// a read leaves its expectation for the monitor before the cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		ict_bus_model_inst.xfer(1'b0, a, 4'hF, 32'h00000000);
	endtask

	// expected timing word: done, illegal, bytes, transfers, clocks
	function automatic logic [31:0] exp_tim(logic [31:0] i, logic b8);
		logic [15:0] c, e;
		logic [3:0] x, by;
		logic w, il;
		e = 16'(ea[4 * i[12:10] +: 4]);
		w = (i[3:0] inside {4'h2, 4'h3, 4'h4, 4'h5}) | i[8];
		il = (i[3:0] > 4'h7) | (i[7:0] == 8'h12 && i[15:14] == 2'h1);
		{c, x, by} = {16'h0000, 4'h0, 4'h1};
		case ({i[3:0], i[7:4]})
		8'h00: {c, by} = {ict_pkg::CLK_OR_RR, 4'h2};
		8'h01: {c, x} = {ict_pkg::CLK_OR_RM + e, 4'h1};
		8'h02: {c, x} = {ict_pkg::CLK_OR_MR + e, 4'h2};
		8'h03, 8'h04: c = ict_pkg::CLK_OR_AI;
		8'h05: {c, x} = {ict_pkg::CLK_OR_MI + e, 4'h2};
		8'h10: {c, x, by} = {ict_pkg::CLK_OUT_IMM, 4'h1, 4'h2};
		8'h11: {c, x} = {ict_pkg::CLK_OUT_PTR, 4'h1};
		8'h20, 8'h21: {c, x} = {ict_pkg::CLK_POP_REG, 4'h1};
		8'h22: {c, x, by} = {ict_pkg::CLK_POP_MEM + e, 4'h2, 4'h2};
		8'h30: {c, x} = {ict_pkg::CLK_RESTORE, 4'h1};
		8'h40: {c, x} = {ict_pkg::CLK_PUSH_REG, 4'h1};
		8'h41: {c, x} = {ict_pkg::CLK_PUSH_SEG, 4'h1};
		8'h42: {c, x, by} = {ict_pkg::CLK_PUSH_MEM + e, 4'h2, 4'h2};
		8'h50: {c, x} = {ict_pkg::CLK_SAVE, 4'h1};
		8'h60, 8'h70: {c, by} = {ict_pkg::CLK_ROT_ONE, 4'h2};
		8'h61, 8'h71: {c, by} = {ict_pkg::CLK_ROT_CNT, 4'h2};
		8'h62, 8'h72: {c, x, by} = {ict_pkg::CLK_ROT_MEM1 + e, 4'h2, 4'h2};
		8'h63, 8'h73: {c, x, by} = {ict_pkg::CLK_ROT_MEMC + e, 4'h2, 4'h2};
		default: ;
		endcase
		if (i[3:1] == 3'h3 && i[4])
			c = c + 16'(i[23:16]) * ict_pkg::CLK_PER_BIT;
		if (w && (b8 || i[9]))
			c = c + 16'(x) * ict_pkg::CLK_WORD_PEN;
		return {5'h00, 1'b1, 1'b0, il, by, x, c};
	endfunction

	// expected result word with its compare mask in the top half
	function automatic logic [63:0] exp_res(logic [31:0] i);
		logic [15:0] r, f;
		logic [31:0] m;
		r = 16'h0000;
		f = stk[15:0];
		m = {ict_pkg::FLAG_MASK, 16'h0000};
		case (i[3:0])
		4'h0:
		begin
			r = opnd[15:0] | opnd[31:16];
			f = (f & 16'hF72A) | {8'h00, r[15], r == 16'h0000, 3'h0,
				~^r[7:0], 2'h0};
			m = {ict_pkg::FLAG_MASK, 16'hFFFF};
		end
		4'h1: {r, m} = {opnd[15:0], ict_pkg::FLAG_MASK, 16'hFFFF};
		4'h3: f = stk[31:16];
		4'h5: {r, m} = {stk[15:0], ict_pkg::FLAG_MASK, 16'hFFFF};
		4'h6, 4'h7:
		begin
			m = {ict_pkg::FLAG_MASK & 16'hF7FE, 16'h0000};
			if (i[7:4] == 4'h0)
			begin
				r = i[0] ? {stk[0], opnd[15:1]} : {opnd[14:0], stk[0]};
				f[ict_pkg::F_C] = i[0] ? opnd[0] : opnd[15];
				f[ict_pkg::F_O] = r[15] ^ (i[0] ? r[14] : f[ict_pkg::F_C]);
				m = {ict_pkg::FLAG_MASK, 16'hFFFF};
			end
		end
		default: ;
		endcase
		// byte forms: only the control flags are predicted
		if (!i[8] && i[3:0] inside {4'h0, 4'h1, 4'h6, 4'h7})
			m = 32'h07000000;
		return {m, f, r};
	endfunction

	// load operands, start, wait out busy, then read timing and result
	task automatic run(input logic [31:0] i, input logic b8,
		input logic poke);
		t = exp_tim(i, b8);
		wr(ict_pkg::OFF_OPND, opnd);
		wr(ict_pkg::OFF_STACK, stk);
		wr(ict_pkg::OFF_INSTR, i);
		if (!t[24])
			bexp_q.push_back(int'(t[15:0]));
		wr(ict_pkg::OFF_CTRL, {30'h0, b8, 1'b1});
		if (poke)
			wr(ict_pkg::OFF_CTRL, {30'h0, b8, 1'b1});
		n = 0;
		while (busy !== 1'b0 && n < 3000)
		begin
			n++;
			@(posedge clock);
		end
		rd(ict_pkg::OFF_TIMING, t, t[24] ? 32'h07000000 :
			(i[3:0] == 4'h0 ? 32'h070FFFFF : 32'h07FFFFFF));
		if (!t[24])
		begin
			er = exp_res(i);
			{last_m, last_r} = er;
		end
		rd(ict_pkg::OFF_RESULT, last_r, last_m);
	endtask

	// scoreboard: reads checked on ack, busy spans checked as they end
	always @(posedge clock)
	begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
		begin
			n_compared++;
			if ((drd & msk_q[0]) !== (exp_q[0] & msk_q[0]))
			begin
				failures++;
				$display("BAD %0t read %h want %h", $time, drd, exp_q[0]);
			end
			exp_q.delete(0);
			msk_q.delete(0);
		end
		if (busy === 1'b1)
			bcnt++;
		else if (bcnt > 0)
		begin
			n_compared++;
			if (bexp_q.size() == 0 || bcnt != bexp_q[0])
			begin
				failures++;
				$display("BAD %0t busy span %0d", $time, bcnt);
			end
			if (bexp_q.size() > 0)
				bexp_q.delete(0);
			bcnt = 0;
		end
	end

	task automatic final_report;
		if (exp_q.size() != 0 || bexp_q.size() != 0)
			failures++;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog, well beyond the expected run length
	initial
	begin
		#(20 * 40000);
		failures++;
		final_report;
	end

	initial
	begin
		rst_n = 1'b0;
		{failures, n_compared, bcnt, n} = '0;
		{opnd, stk, ea, last_r} = '0;
		last_m = 32'hFFFFFFFF;
		void'($urandom(55));
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		for (int a = 0; a < 8; a++)
			rd(8'(4 * a), 32'h00000000, 32'hFFFFFFFF);
		$display("test reset done");
		wr(ict_pkg::OFF_OPND, 32'hFFFFFFFF);
		ict_bus_model_inst.xfer(1'b1, ict_pkg::OFF_OPND, 4'h5, 32'h12345678);
		rd(ict_pkg::OFF_OPND, 32'hFF34FF78, 32'hFFFFFFFF);
		wr(8'h1C, 32'hFFFFFFFF);
		rd(8'h1C, 32'h00000000, 32'hFFFFFFFF);
		ea = $urandom;
		wr(ict_pkg::OFF_EA_TAB, ea);
		rd(ict_pkg::OFF_EA_TAB, ea, 32'hFFFFFFFF);
		$display("test registers done");
		// every operand form on wide-odd, narrow and byte settings
		for (int k = 0; k < 3; k++)
			for (int op = 0; op < 8; op++)
				for (int fm = 0; fm < nf[op]; fm++)
				begin
					opnd = $urandom;
					stk = $urandom;
					ins = {8'h00, 8'($urandom % 16), 2'(k), 1'b0,
						3'($urandom), k != 1, k != 2, 4'(fm), 4'(op)};
					run(ins, k == 1, 1'b0);
				end
		$display("test forms done");
		opnd = 32'h00000000;
		run(32'h00000100, 1'b0, 1'b0);
		run(32'h00000108, 1'b0, 1'b0);
		$display("test illegal done");
		run(32'h00C80016, 1'b0, 1'b1);
		$display("test start while busy done");
		final_report;
	end
endmodule
